/* core/link_rx_defines.svh */
`ifndef LINK_RX_DEFINES_SVH
`define LINK_RX_DEFINES_SVH

// width of a received dword handed to the transport layer
`define LINK_RX_DWORD_W 32

// reset values of the link-side outputs
`define LINK_RX_NOTIFY_RST 1'h0
`define LINK_RX_VALID_RST  1'h0
`define LINK_RX_READY_RST  1'h1
`define LINK_RX_DATA_RST   32'h0000_0000

`endif

/* core/link_rx_pkg.sv */
package link_rx_pkg;

  // dword classes seen on or sent to the phy layer; prim_data is a plain data dword
  typedef enum logic [3:0] {
    prim_data,
    prim_x_rdy,
    prim_sof,
    prim_eof,
    prim_hold,
    prim_holda,
    prim_sync,
    prim_wtrm,
    prim_r_rdy,
    prim_r_ip,
    prim_r_ok,
    prim_r_err,
    prim_dmat,
    prim_other
  } prim_type;

  // receive-side link states
  typedef enum logic [3:0] {
    idle_state,
    wait_for_fifo_state,
    receive_ready_check_state,
    data_receive_state,
    data_hold_state,
    hold_ack_state,
    frame_end_check_state,
    crc_ok_state,
    good_end_state,
    bad_end_state,
    no_comm_error_state
  } link_state_type;

endpackage

/* core/link_frame_receive_fsm.sv */
`timescale 1ns/100ps
`include "link_rx_defines.svh"
module link_frame_receive_fsm #(
  parameter bit IS_HOST = 1'b1,
  parameter int DWORD_W = `LINK_RX_DWORD_W
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 phy_ready,
  input  wire link_rx_pkg::prim_type rx_prim,
  input  wire logic [DWORD_W-1:0]   rx_data,
  input  wire logic                 fifo_ready,
  input  wire logic                 fifo_space,
  input  wire logic                 terminate_req,
  input  wire logic                 ctrl_frame_req,
  input  wire logic                 crc_done,
  input  wire logic                 crc_good,
  input  wire logic                 tl_good,
  input  wire logic                 tl_unrecognized,
  input  wire logic                 tl_error,
  input  wire logic                 link_error,
  input  wire logic                 out_ready,
  output link_rx_pkg::prim_type     tx_prim,
  output logic                      out_valid,
  output logic [DWORD_W-1:0]        out_data,
  output logic                      notify_crc_ok,
  output logic                      notify_no_comm,
  output logic                      notify_fail,
  output logic                      notify_protocol,
  output logic                      notify_abort
);
  import link_rx_pkg::*;

  link_state_type state;
  link_state_type next_state;
  logic           next_crc_ok;
  logic           next_no_comm;
  logic           next_protocol;
  logic           next_abort;
  logic           skid_valid;
  logic [DWORD_W-1:0] skid_data;
  logic           buf_ready;

  // primitive transmitted while sitting in a given state
  function automatic prim_type tx_for(input link_state_type st, input logic term);
    tx_for = prim_sync; // unused state codes fall back to SYNC
    unique case (st)
      receive_ready_check_state: tx_for = prim_r_rdy;
      data_receive_state:        tx_for = term ? prim_dmat : prim_r_ip;
      data_hold_state:           tx_for = prim_hold;
      hold_ack_state:            tx_for = term ? prim_dmat : prim_holda;
      frame_end_check_state:     tx_for = prim_r_ip;
      crc_ok_state:              tx_for = prim_r_ip;
      good_end_state:            tx_for = prim_r_ok;
      bad_end_state:             tx_for = prim_r_err;
      idle_state,
      wait_for_fifo_state,
      no_comm_error_state:       tx_for = prim_sync;
    endcase
  endfunction

  // received dword decode
  wire is_x_rdy   = (rx_prim == prim_x_rdy);
  wire is_sof     = (rx_prim == prim_sof);
  wire is_eof     = (rx_prim == prim_eof);
  wire is_hold    = (rx_prim == prim_hold);
  wire is_sync    = (rx_prim == prim_sync);
  wire is_wtrm    = (rx_prim == prim_wtrm);
  wire is_data    = (rx_prim == prim_data);
  // control frame pre-emption only exists on the host end
  wire ctrl_abort = IS_HOST && ctrl_frame_req;
  // room for another dword: transport space and a free buffer slot
  wire room       = fifo_space && buf_ready;
  wire in_frame   = (state != idle_state) && (state != no_comm_error_state);
  wire push       = is_data && buf_ready &&
                    ((state == data_receive_state) || (state == data_hold_state));

  // next state and notification decode; inside a frame phy loss outranks every dword
  always_comb begin
    next_state    = state;
    next_crc_ok   = 1'b0;
    next_no_comm  = 1'b0;
    next_protocol = 1'b0;
    next_abort    = 1'b0;
    if (in_frame && !phy_ready) begin
      next_state   = no_comm_error_state;
      next_no_comm = 1'b1;
    end else begin
      unique case (state)
        idle_state: begin
          if (is_x_rdy) begin
            next_state = fifo_ready ? receive_ready_check_state
                                    : wait_for_fifo_state;
          end
        end
        wait_for_fifo_state: begin
          if (is_x_rdy && fifo_ready) begin
            next_state = receive_ready_check_state;
          end else if (!is_x_rdy) begin
            next_state    = idle_state;
            next_protocol = 1'b1;
          end
        end
        receive_ready_check_state: begin
          if (is_sof) begin
            next_state = data_receive_state;
          end else if (!is_x_rdy) begin
            next_state    = idle_state;
            next_protocol = 1'b1;
          end // X_RDY keeps waiting
        end
        data_receive_state: begin
          if (ctrl_abort) begin
            next_state = idle_state;
          end else if (is_hold) begin
            next_state = hold_ack_state;
          end else if (is_eof) begin
            next_state = frame_end_check_state;
          end else if (is_wtrm) begin
            next_state = bad_end_state;
          end else if (is_sync) begin
            next_state = idle_state;
            next_abort = 1'b1;
          end else if (is_data && !room) begin
            next_state = data_hold_state;
          end
        end
        data_hold_state: begin
          if (ctrl_abort) begin
            next_state = idle_state;
          end else if (is_eof) begin
            next_state = frame_end_check_state;
          end else if (is_sync) begin
            next_state = idle_state;
            next_abort = 1'b1;
          end else if (room) begin
            next_state = is_hold ? hold_ack_state : data_receive_state;
          end
        end
        hold_ack_state: begin
          if (ctrl_abort) begin
            next_state = idle_state;
          end else if (is_hold) begin
            next_state = hold_ack_state;
          end else if (is_eof) begin
            next_state = frame_end_check_state;
          end else if (is_sync) begin
            next_state = idle_state;
            next_abort = 1'b1;
          end else begin
            next_state = data_receive_state;
          end
        end
        frame_end_check_state: begin
          if (crc_done) begin
            next_state  = crc_good ? crc_ok_state : bad_end_state;
            next_crc_ok = crc_good;
          end
        end
        crc_ok_state: begin
          if (is_sync) begin
            next_state = idle_state;
          end else if (tl_unrecognized || tl_error || link_error) begin
            next_state = bad_end_state;
          end else if (tl_good) begin
            next_state = good_end_state;
          end // no verdict yet: stay
        end
        good_end_state: begin
          if (is_sync) begin
            next_state = idle_state;
          end
        end
        bad_end_state: begin
          if (is_sync) begin
            next_state = idle_state;
          end
        end
        no_comm_error_state: begin
          // linger until the phy comes back, then rejoin idle
          if (phy_ready) begin
            next_state = idle_state;
          end
        end
      endcase
    end
  end

  // state, transmit primitive and notification pulses all register together
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state           <= idle_state;
      tx_prim         <= prim_sync;
      notify_crc_ok   <= `LINK_RX_NOTIFY_RST;
      notify_no_comm  <= `LINK_RX_NOTIFY_RST;
      notify_fail     <= `LINK_RX_NOTIFY_RST;
      notify_protocol <= `LINK_RX_NOTIFY_RST;
      notify_abort    <= `LINK_RX_NOTIFY_RST;
    end else begin
      state           <= next_state;
      tx_prim         <= tx_for(next_state, terminate_req);
      notify_crc_ok   <= next_crc_ok;
      notify_no_comm  <= next_no_comm;
      notify_fail     <= next_no_comm;
      notify_protocol <= next_protocol;
      notify_abort    <= next_abort;
    end
  end

  // two-entry skid buffer toward the transport layer; the spare slot
  // absorbs the dword already in flight when the receiver stalls
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_valid  <= `LINK_RX_VALID_RST;
      out_data   <= `LINK_RX_DATA_RST;
      skid_valid <= `LINK_RX_VALID_RST;
      skid_data  <= `LINK_RX_DATA_RST;
      buf_ready  <= `LINK_RX_READY_RST;
    end else if (!out_valid || out_ready) begin
      out_valid  <= skid_valid || push;
      out_data   <= skid_valid ? skid_data : rx_data;
      skid_valid <= 1'b0;
      buf_ready  <= 1'b1;
    end else if (push) begin
      skid_valid <= 1'b1;
      skid_data  <= rx_data;
      buf_ready  <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // hold-ack answer and exits; DMAT follows the terminate request of the cycle before
  hold_ack_send_a: assert property (
    state == hold_ack_state |-> tx_prim == ($past(terminate_req) ? prim_dmat : prim_holda))
    else $error("wrong primitive in hold-ack");
  hold_ack_move_a: assert property (
    state == hold_ack_state && phy_ready && !ctrl_abort && is_eof
    |=> state == frame_end_check_state)
    else $error("EOF in hold-ack not taken");
  ctrl_abort_idle_a: assert property (
    state == hold_ack_state && phy_ready && ctrl_abort
    |=> state == idle_state ##0 tx_prim == prim_sync)
    else $error("control frame did not abandon");

  // phy loss wins over any dword while a frame is open
  phy_loss_error_a: assert property (
    in_frame && !phy_ready
    |=> state == no_comm_error_state && notify_no_comm && notify_fail)
    else $error("phy loss not handled");
  ready_check_loss_a: assert property (
    state == receive_ready_check_state && !phy_ready
    |=> state == no_comm_error_state && notify_no_comm)
    else $error("phy loss in check-ready not handled");
  no_comm_exit_a: assert property (
    state == no_comm_error_state && phy_ready |=> state == idle_state)
    else $error("no-comm state not left");

  // frame opening handshake
  ready_check_send_a: assert property (
    state == idle_state && is_x_rdy && fifo_ready
    |=> state == receive_ready_check_state && tx_prim == prim_r_rdy)
    else $error("X_RDY not answered ready");
  ready_check_stay_a: assert property (
    state == receive_ready_check_state && phy_ready && is_x_rdy
    |=> state == receive_ready_check_state)
    else $error("check-ready left on X_RDY");
  sof_data_start_a: assert property (
    state == receive_ready_check_state && phy_ready && is_sof
    |=> state == data_receive_state)
    else $error("SOF did not start data");
  ready_check_bad_a: assert property (
    state == receive_ready_check_state && phy_ready && !is_x_rdy && !is_sof
    |=> state == idle_state && notify_protocol)
    else $error("stray dword in check-ready");
  fifo_wait_entry_a: assert property (
    state == idle_state && is_x_rdy && !fifo_ready
    |=> state == wait_for_fifo_state ##0 tx_prim == prim_sync)
    else $error("no FIFO wait");

  // crc verdict; the valid-crc note may only fire on entry from the frame-end check
  crc_wait_a: assert property (
    state == frame_end_check_state && phy_ready && !crc_done
    |=> state == frame_end_check_state && tx_prim == prim_r_ip)
    else $error("frame-end check left early");
  crc_valid_note_a: assert property (
    state == frame_end_check_state && phy_ready && crc_done && crc_good
    |=> state == crc_ok_state && notify_crc_ok ##1 !notify_crc_ok)
    else $error("crc valid not reported once");
  crc_note_once_a: assert property (
    notify_crc_ok |-> state == crc_ok_state && $past(state) == frame_end_check_state)
    else $error("crc valid reported outside entry");
  crc_fail_end_a: assert property (
    state == frame_end_check_state && phy_ready && crc_done && !crc_good
    |=> state == bad_end_state ##0 tx_prim == prim_r_err)
    else $error("bad CRC not ending bad");

  // good-crc state waits for the transport verdict
  crc_ok_good_a: assert property (
    state == crc_ok_state |-> tx_prim == prim_r_ip)
    else $error("crc-ok not sending R_IP");
  crc_ok_bad_a: assert property (
    state == crc_ok_state && phy_ready && !is_sync
    && (tl_unrecognized || tl_error || link_error) |=> state == bad_end_state)
    else $error("crc-ok error not ending bad");
  crc_ok_wait_a: assert property (
    state == crc_ok_state && phy_ready && !is_sync && !tl_good
    && !tl_unrecognized && !tl_error && !link_error |=> state == crc_ok_state)
    else $error("crc-ok left without verdict");
  good_verdict_a: assert property (
    state == crc_ok_state && phy_ready && !is_sync && tl_good && !tl_unrecognized
    && !tl_error && !link_error |=> state == good_end_state && tx_prim == prim_r_ok)
    else $error("good verdict not ending good");
  crc_sync_idle_a: assert property (
    state == crc_ok_state && phy_ready && is_sync |=> state == idle_state)
    else $error("SYNC in crc-ok not idling");

  // both end states hold their answer until the far end sends SYNC
  good_end_sync_a: assert property (
    state == good_end_state && phy_ready
    |=> ($past(is_sync) ? state == idle_state
         : state == good_end_state && tx_prim == prim_r_ok))
    else $error("good-end primitive mismatch");
  bad_end_hold_a: assert property (
    state == bad_end_state && phy_ready
    |=> ($past(is_sync) ? state == idle_state
         : state == bad_end_state && tx_prim == prim_r_err))
    else $error("bad-end primitive mismatch");

  // a stalled output word must not move; the skid slot takes the next one
  skid_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled output word changed");

  // main scenarios
  good_frame_c: cover property (state == crc_ok_state ##1 state == good_end_state
    ##[1:20] state == idle_state);
  hold_cycle_c: cover property (state == hold_ack_state ##1 state == data_receive_state);
  stall_fill_c: cover property (skid_valid && out_valid && !out_ready);
  fifo_wait_c: cover property (state == wait_for_fifo_state
    ##1 state == receive_ready_check_state);
  phy_loss_c: cover property (state == hold_ack_state ##1 state == no_comm_error_state);
endmodule

/* tb/far_end_tx.sv */
`timescale 1ns/100ps
// far-end transmitting link: forwards the bench's dword, drops its frame on our SYNC
module far_end_tx (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire link_rx_pkg::prim_type tx_prim,
  input  wire link_rx_pkg::prim_type cmd_prim,
  input  wire logic [31:0]           cmd_data,
  output link_rx_pkg::prim_type      rx_prim,
  output logic [31:0]                rx_data
);
  import link_rx_pkg::*;
  logic        in_frame;
  logic [31:0] churn;
  // once the receiver idles, a stale frame dword must not leak through; a fresh
  // X_RDY opens the next frame and so passes, or a back-to-back frame is lost
  assign rx_prim = (in_frame && tx_prim == prim_sync && cmd_prim != prim_x_rdy)
                   ? prim_sync : cmd_prim;
  // payload outside data dwords keeps moving, so nobody can trust a held value
  assign rx_data = (rx_prim == prim_data) ? cmd_data : churn;
  // frame tracking: opened by SOF, closed by the receiver's SYNC
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_frame <= 1'b0;
      churn    <= 32'h0000_0000;
    end else begin
      churn <= churn + 32'h9E37_79B9;
      if (rx_prim == prim_sof) in_frame <= 1'b1;
      else if (tx_prim == prim_sync) in_frame <= 1'b0;
    end
  end
endmodule

/* tb/tb_link_frame_receive_fsm.sv */
`timescale 1ns/100ps
module tb_link_frame_receive_fsm;
  import link_rx_pkg::*;
  // control bits: phy loss, fifo ready, terminate, ctrl frame, crc and transport verdicts
  localparam logic [9:0] NRDY = 10'h200, FRDY = 10'h100, TERM = 10'h080, CTRL = 10'h040;
  localparam logic [9:0] CDON = 10'h020, CGD = 10'h010, TGD = 10'h008, TUN = 10'h004;
  localparam logic [9:0] TER = 10'h002, LER = 10'h001;
  // notify bits: crc ok, no comm + fail, protocol, abort
  localparam logic [4:0] NCRC = 5'h10, NCOM = 5'h0C, NPRO = 5'h02, NABT = 5'h01;
  typedef struct packed {prim_type tx; logic [4:0] nt;} exp_type;
  logic        ref_clk;
  logic        sys_rst;
  logic        out_ready;
  logic        out_valid;
  logic [9:0]  ctl;
  wire [4:0]   nt;
  logic [31:0] cmd_data;
  logic [31:0] rx_data;
  logic [31:0] out_data;
  prim_type    cmd_prim;
  prim_type    rx_prim;
  prim_type    tx_prim;
  exp_type     q[$];
  logic [31:0] dq[$];
  int          fails;
  int          checks_done;
  int          seed;
  int          i;
  prim_type    vp[5] = '{prim_r_ip, prim_r_ip, prim_r_ip, prim_r_ip, prim_sync};
  logic [9:0]  vc[5] = '{TGD, TUN, TER, LER, 10'h000};
  prim_type    vt[5] = '{prim_r_ok, prim_r_err, prim_r_err, prim_r_err, prim_sync};
  prim_type    ap[3] = '{prim_hold, prim_hold, prim_sync};
  logic [9:0]  ac[3] = '{CTRL, NRDY, 10'h000};
  logic [4:0]  an[3] = '{5'h00, NCOM, NABT};

  link_frame_receive_fsm link_frame_receive_fsm_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .phy_ready(!ctl[9]), .rx_prim(rx_prim),
    .rx_data(rx_data), .fifo_ready(ctl[8]), .fifo_space(1'b1), .terminate_req(ctl[7]),
    .ctrl_frame_req(ctl[6]), .crc_done(ctl[5]), .crc_good(ctl[4]), .tl_good(ctl[3]),
    .tl_unrecognized(ctl[2]), .tl_error(ctl[1]), .link_error(ctl[0]), .out_ready(out_ready),
    .tx_prim(tx_prim), .out_valid(out_valid), .out_data(out_data), .notify_crc_ok(nt[4]),
    .notify_no_comm(nt[3]), .notify_fail(nt[2]), .notify_protocol(nt[1]),
    .notify_abort(nt[0]));

  far_end_tx far_end_tx_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .tx_prim(tx_prim), .cmd_prim(cmd_prim),
    .cmd_data(cmd_data), .rx_prim(rx_prim), .rx_data(rx_data));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (e !== s) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one dword per cycle; prim_other as expectation means the primitive is not judged
  task automatic st(prim_type p, logic [9:0] c, prim_type e, logic [4:0] n);
    cmd_prim = p;
    ctl = c;
    cmd_data = $random(seed);
    out_ready = $random(seed);
    if (p == prim_data) dq.push_back(cmd_data);
    @(posedge ref_clk);
    q.push_back('{e, n});
    #1;
  endtask

  // frame up to the crc-ok state with no transport verdict yet
  task automatic fr();
    st(prim_x_rdy, FRDY, prim_r_rdy, 0);
    st(prim_sof, 0, prim_r_ip, 0);
    st(prim_data, 0, prim_r_ip, 0);
    st(prim_eof, 0, prim_r_ip, 0);
    st(prim_r_ip, CDON | CGD, prim_r_ip, NCRC);
    st(prim_r_ip, 0, prim_r_ip, 0);
  endtask

  task automatic pre();
    st(prim_x_rdy, FRDY, prim_r_rdy, 0);
    st(prim_sof, 0, prim_r_ip, 0);
    st(prim_hold, 0, prim_holda, 0);
  endtask

  // results one cycle after their inputs; settled by the falling edge
  always @(negedge ref_clk) begin
    exp_type x;
    if (q.size() > 0) begin
      x = q.pop_front();
      if (x.tx != prim_other) chk("tx_prim", x.tx, tx_prim);
      chk("notify", x.nt, nt);
    end
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (dq.size() == 0) chk("unexpected word", 0, 1);
      else chk("out_data", dq.pop_front(), out_data);
    end
  end

  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    seed = 77;
    fails = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    ctl = 10'h000;
    cmd_prim = prim_sync;
    cmd_data = 32'h0000_0000;
    out_ready = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    // hold handshake, terminate, eof from hold-ack, failed crc
    st(prim_x_rdy, FRDY, prim_r_rdy, 0);
    st(prim_x_rdy, FRDY, prim_r_rdy, 0);
    st(prim_sof, 0, prim_r_ip, 0);
    st(prim_data, 0, prim_r_ip, 0);
    st(prim_hold, 0, prim_holda, 0);
    st(prim_hold, TERM, prim_dmat, 0);
    st(prim_hold, TERM, prim_dmat, 0);
    st(prim_eof, 0, prim_r_ip, 0);
    st(prim_r_ip, 0, prim_r_ip, 0);
    st(prim_r_ip, CDON, prim_r_err, 0);
    st(prim_r_ip, 0, prim_r_err, 0);
    st(prim_sync, 0, prim_sync, 0);
    // every transport verdict, and SYNC, in the crc-ok state
    for (i = 0; i < 5; i++) begin
      fr();
      st(vp[i], vc[i], vt[i], 0);
      st(prim_r_ip, 0, vt[i], 0);
      st(prim_sync, 0, prim_sync, 0);
    end
    // hold-ack left by control frame, phy loss and SYNC
    for (i = 0; i < 3; i++) begin
      pre();
      st(ap[i], ac[i], prim_sync, an[i]);
      st(prim_sync, 0, prim_sync, 0);
    end
    // check-ready left by a stray dword and by phy loss
    st(prim_x_rdy, FRDY, prim_r_rdy, 0);
    st(prim_other, 0, prim_sync, NPRO);
    st(prim_x_rdy, FRDY, prim_r_rdy, 0);
    st(prim_x_rdy, NRDY, prim_sync, NCOM);
    st(prim_sync, 0, prim_sync, 0);
    // no fifo room: wait instead of answering ready
    st(prim_x_rdy, 0, prim_sync, 0);
    st(prim_x_rdy, FRDY, prim_r_rdy, 0);
    st(prim_sof, 0, prim_r_ip, 0);
    st(prim_sync, 0, prim_sync, NABT);
    st(prim_sync, 0, prim_sync, 0);
    // drain whatever is still buffered, bounded
    out_ready = 1'b1;
    for (i = 0; i < 20 && dq.size() > 0; i++) @(posedge ref_clk);
    #1;
    if (dq.size() > 0) chk("words left", 0, dq.size());
    summarize();
  end
endmodule
